// File: design/spdc_map.vh
`ifndef SPDC_MAP_VH
`define SPDC_MAP_VH
// register byte offsets on the axi4-lite slave
`define SPDC_OFS_CTRL      8'h00
`define SPDC_OFS_CHSEL     8'h04
`define SPDC_OFS_PTR_LOC   8'h08
`define SPDC_OFS_PTR_WORD  8'h0C
`define SPDC_OFS_STATUS    8'h10
// control register bits, write-one pulses
`define SPDC_CTRL_ABORT    0
`define SPDC_CTRL_ACT      1
`define SPDC_CTRL_LOAD     2
// pointer word layout
`define SPDC_PTR_STAT_HI   23
`define SPDC_PTR_STAT_LO   12
`define SPDC_PTR_Y_HI      11
`define SPDC_PTR_Y_LO      0
// pointer location window, octal 31 to 37
`define SPDC_PTR_LOC_MIN   5'h19
`define SPDC_PTR_LOC_MAX   5'h1F
`define SPDC_PTR_LOC_RST   5'h19
// command word layout
`define SPDC_CMD_DEV_HI    11
`define SPDC_CMD_DEV_LO    6
`define SPDC_CMD_OP_HI     5
`define SPDC_CMD_OP_LO     0
`define SPDC_OP_DIR_IN     5
// count word and address word fields
`define SPDC_CNT_HI        15
`define SPDC_ADR_HI        15
// status field bits
`define SPDC_ST_DONE       0
`define SPDC_ST_PARERR     1
`define SPDC_ST_ABORT      2
`define SPDC_ST_INPUT      3
`define SPDC_ST_CH_LO      4
`define SPDC_ST_CH_HI      5
// axi response codes
`define SPDC_RESP_OKAY     2'h0
`define SPDC_RESP_SLVERR   2'h2
`endif

// File: design/spdc_top.v
`timescale 1ns/100ps
`include "spdc_map.vh"

////////////////////////////////////////////////////////////////////////////////
module spdc_fifo #(
	parameter W     = 24,
	parameter DEPTH = 32,
	parameter AW    = 5
) (
	// clock and reset
	input  wire          aclk,
	input  wire          aresetn,
	input  wire          flush,
	// fill side
	input  wire          in_valid,
	output wire          in_ready,
	input  wire [W-1:0]  in_data,
	// drain side
	output wire          out_valid,
	input  wire          out_ready,
	output wire [W-1:0]  out_data,
	output wire [AW:0]   level
);
	reg [W-1:0]  mem [0:DEPTH-1];
	reg [AW-1:0] wr_r;
	reg [AW-1:0] rd_r;
	reg [AW:0]   cnt_r;
	wire         push;
	wire         pop;

	assign in_ready  = (cnt_r != DEPTH[AW:0]);
	assign out_valid = (cnt_r != {(AW+1){1'b0}});
	assign out_data  = mem[rd_r];
	assign level     = cnt_r;
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// storage has no reset, only pointers and count do
	always @(posedge aclk) begin
		if (push)
			mem[wr_r] <= in_data;
	end

	// pointers wrap on power-of-two depth
	always @(posedge aclk) begin
		if (!aresetn || flush) begin
			wr_r  <= {AW{1'b0}};
			rd_r  <= {AW{1'b0}};
			cnt_r <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_r <= wr_r + 1'b1;
			if (pop)
				rd_r <= rd_r + 1'b1;
			cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end
endmodule // spdc_fifo

////////////////////////////////////////////////////////////////////////////////
module spdc_top #(
	parameter NUM_CH  = 4,
	parameter FDEPTH  = 32,
	parameter FAW     = 5
) (
	// clock and reset
	input  wire              aclk,
	input  wire              aresetn,
	// axi4-lite write channels
	input  wire [7:0]        s_axi_awaddr,
	input  wire              s_axi_awvalid,
	output reg               s_axi_awready,
	input  wire [31:0]       s_axi_wdata,
	input  wire [3:0]        s_axi_wstrb,
	input  wire              s_axi_wvalid,
	output reg               s_axi_wready,
	output reg  [1:0]        s_axi_bresp,
	output reg               s_axi_bvalid,
	input  wire              s_axi_bready,
	// axi4-lite read channels
	input  wire [7:0]        s_axi_araddr,
	input  wire              s_axi_arvalid,
	output reg               s_axi_arready,
	output reg  [31:0]       s_axi_rdata,
	output reg  [1:0]        s_axi_rresp,
	output reg               s_axi_rvalid,
	input  wire              s_axi_rready,
	// shared direct memory channel
	output reg               mem_req,
	output reg               mem_we,
	output reg  [15:0]       mem_addr,
	output reg  [23:0]       mem_wdata,
	input  wire              mem_gnt,
	input  wire [23:0]       mem_rdata,
	// processor side
	output reg               ready_irq,
	// peripheral channels
	output reg  [NUM_CH-1:0] per_sel,
	output reg               per_load,
	output reg               per_cmd_valid,
	output reg  [11:0]       per_cmd,
	input  wire [NUM_CH-1:0] per_cmd_ack,
	output reg               per_tx_valid,
	output reg  [23:0]       per_tx_data,
	output reg               per_tx_par,
	input  wire [NUM_CH-1:0] per_tx_ready,
	input  wire [NUM_CH-1:0] per_rx_valid,
	input  wire [23:0]       per_rx_data,
	input  wire              per_rx_par,
	output reg               per_rx_ready
);
	localparam S_IDLE  = 3'd0;
	localparam S_CMD   = 3'd1;
	localparam S_CNT   = 3'd2;
	localparam S_ADR   = 3'd3;
	localparam S_ISSUE = 3'd4;
	localparam S_XFER  = 3'd5;
	localparam S_STAT  = 3'd6;
	localparam S_DONE  = 3'd7;

	reg [2:0]   state_r;
	reg [1:0]   chsel_r;
	reg [4:0]   ptr_loc_r;
	reg [23:0]  ptr_word_r;
	reg [11:0]  cmd_r;
	reg [15:0]  cnt_r;
	reg [15:0]  adr_r;
	reg [15:0]  issued_r;
	reg [15:0]  done_r;
	reg [11:0]  status_r;
	reg         parerr_r;
	reg         abort_pend_r;
	reg         aw_hold_r;
	reg         w_hold_r;
	reg [7:0]   aw_addr_r;
	reg [31:0]  w_data_r;
	reg         w_strb0_r;
	reg         fifo_flush_r;
	wire        wr_fire;
	wire        start;
	wire        abort_set;
	wire        act_set;
	wire        dir_in;
	wire        tx_rdy_sel;
	wire        rx_vld_sel;
	wire        ack_sel;
	wire        rx_take;
	wire        tx_load;
	wire        fin_valid;
	wire        fin_ready;
	wire [23:0] fin_data;
	wire        fout_valid;
	wire        fout_ready;
	wire [23:0] fout_data;
	wire [FAW:0] flevel;
	wire        busy;

	assign busy       = (state_r != S_IDLE);
	assign dir_in     = cmd_r[`SPDC_OP_DIR_IN];
	assign tx_rdy_sel = per_tx_ready[chsel_r];
	assign rx_vld_sel = per_rx_valid[chsel_r];
	assign ack_sel    = per_cmd_ack[chsel_r];

	////////////////////////////////////////////////////////////////////////
	// axi4-lite write: address and data taken in either order
	assign wr_fire   = aw_hold_r & w_hold_r & ~s_axi_bvalid;
	assign start     = wr_fire & (aw_addr_r == `SPDC_OFS_PTR_WORD) & ~busy & w_strb0_r;
	assign abort_set = wr_fire & (aw_addr_r == `SPDC_OFS_CTRL) & w_data_r[`SPDC_CTRL_ABORT];
	assign act_set   = wr_fire & (aw_addr_r == `SPDC_OFS_CTRL) & w_data_r[`SPDC_CTRL_ACT];

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `SPDC_RESP_OKAY;
			aw_hold_r     <= 1'b0;
			w_hold_r      <= 1'b0;
			aw_addr_r     <= 8'h00;
			w_data_r      <= 32'h00000000;
			w_strb0_r     <= 1'b0;
			chsel_r       <= 2'h0;
			ptr_loc_r     <= `SPDC_PTR_LOC_RST;
			per_load      <= 1'b0;
		end else begin
			s_axi_awready <= ~aw_hold_r & ~s_axi_awready;
			s_axi_wready  <= ~w_hold_r & ~s_axi_wready;
			per_load      <= 1'b0;
			if (s_axi_awvalid & s_axi_awready) begin
				aw_hold_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_hold_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				// strobe kept with its data, the master may move it after the take
				w_strb0_r <= s_axi_wstrb[0];
			end
			if (s_axi_bvalid & s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (wr_fire) begin
				aw_hold_r    <= 1'b0;
				w_hold_r     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= `SPDC_RESP_OKAY;
				case (aw_addr_r)
				`SPDC_OFS_CTRL:
					per_load <= w_data_r[`SPDC_CTRL_LOAD];
				`SPDC_OFS_CHSEL:
					// switching mid-operation would strand a transfer
					if (!busy && w_data_r < NUM_CH)
						chsel_r <= w_data_r[1:0];
				`SPDC_OFS_PTR_LOC:
					if (!busy && w_data_r[31:5] == 27'h0000000 && w_data_r[4:0] >= `SPDC_PTR_LOC_MIN)
						ptr_loc_r <= w_data_r[4:0];
				`SPDC_OFS_PTR_WORD, `SPDC_OFS_STATUS: begin
				end
				default:
					s_axi_bresp <= `SPDC_RESP_SLVERR;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// axi4-lite read: one word a time, answer one cycle after address
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `SPDC_RESP_OKAY;
		end else begin
			s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
			if (s_axi_rvalid & s_axi_rready)
				s_axi_rvalid <= 1'b0;
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `SPDC_RESP_OKAY;
				case (s_axi_araddr)
				`SPDC_OFS_CTRL:     s_axi_rdata <= {31'h00000000, abort_pend_r};
				`SPDC_OFS_CHSEL:    s_axi_rdata <= {30'h00000000, chsel_r};
				`SPDC_OFS_PTR_LOC:  s_axi_rdata <= {27'h0000000, ptr_loc_r};
				`SPDC_OFS_PTR_WORD: s_axi_rdata <= {8'h00, ptr_word_r};
				`SPDC_OFS_STATUS:   s_axi_rdata <= {8'h00, done_r, status_r[3:0], busy, state_r};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `SPDC_RESP_SLVERR;
				end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// data buffer, direction set by opcode
	assign rx_take    = rx_vld_sel & per_rx_ready;
	assign fin_valid  = dir_in ? rx_take : (mem_req & mem_gnt & ~mem_we & (state_r == S_XFER));
	assign fin_data   = dir_in ? per_rx_data : mem_rdata;
	assign tx_load    = ~dir_in & fout_valid & (~per_tx_valid | tx_rdy_sel);
	assign fout_ready = dir_in ? (~mem_req & (state_r == S_XFER) & ~abort_pend_r) : tx_load;

	spdc_fifo #(
		.W     (24),
		.DEPTH (FDEPTH),
		.AW    (FAW)
	) u_fifo (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.flush     (fifo_flush_r),
		.in_valid  (fin_valid),
		.in_ready  (fin_ready),
		.in_data   (fin_data),
		.out_valid (fout_valid),
		.out_ready (fout_ready),
		.out_data  (fout_data),
		.level     (flevel)
	);

	////////////////////////////////////////////////////////////////////////
	// sequencer: pointer, three control words, command, data, status
	always @(posedge aclk) begin
		if (!aresetn) begin
			state_r       <= S_IDLE;
			ptr_word_r    <= 24'h000000;
			cmd_r         <= 12'h000;
			cnt_r         <= 16'h0000;
			adr_r         <= 16'h0000;
			issued_r      <= 16'h0000;
			done_r        <= 16'h0000;
			status_r      <= 12'h000;
			parerr_r      <= 1'b0;
			abort_pend_r  <= 1'b0;
			fifo_flush_r  <= 1'b0;
			mem_req       <= 1'b0;
			mem_we        <= 1'b0;
			mem_addr      <= 16'h0000;
			mem_wdata     <= 24'h000000;
			ready_irq     <= 1'b0;
			per_sel       <= {NUM_CH{1'b0}};
			per_cmd_valid <= 1'b0;
			per_cmd       <= 12'h000;
			per_tx_valid  <= 1'b0;
			per_tx_data   <= 24'h000000;
			per_tx_par    <= 1'b0;
			per_rx_ready  <= 1'b0;
		end else begin
			ready_irq    <= act_set;
			fifo_flush_r <= 1'b0;
			// set wins over the sequencer's clear
			if (abort_set && busy)
				abort_pend_r <= 1'b1;
			else if (state_r == S_DONE)
				abort_pend_r <= 1'b0;
			// selector drives exactly one channel while busy
			per_sel <= busy ? ({{(NUM_CH-1){1'b0}}, 1'b1} << chsel_r) : {NUM_CH{1'b0}};
			// hold the request until this controller wins the channel
			if (mem_req && mem_gnt)
				mem_req <= 1'b0;
			// registered ready keeps two slots of margin for the lag
			per_rx_ready <= (state_r == S_XFER) & dir_in & ~abort_pend_r &
				(issued_r < cnt_r) & (flevel < FDEPTH - 2) & ~rx_take;
			// output stage, parity formed here
			if (per_tx_valid && tx_rdy_sel) begin
				per_tx_valid <= 1'b0;
				done_r       <= done_r + 16'h0001;
			end
			if (tx_load) begin
				per_tx_valid <= 1'b1;
				per_tx_data  <= fout_data;
				per_tx_par   <= ~^fout_data;
			end
			case (state_r)
			S_IDLE: begin
				if (start) begin
					ptr_word_r <= w_data_r[23:0];
					parerr_r   <= 1'b0;
					issued_r   <= 16'h0000;
					done_r     <= 16'h0000;
					mem_req    <= 1'b1;
					mem_we     <= 1'b0;
					mem_addr   <= {4'h0, w_data_r[`SPDC_PTR_Y_HI:`SPDC_PTR_Y_LO]};
					state_r    <= S_CMD;
				end
			end
			S_CMD: begin
				if (mem_req && mem_gnt) begin
					cmd_r    <= mem_rdata[`SPDC_CMD_DEV_HI:`SPDC_CMD_OP_LO];
					mem_req  <= 1'b1;
					mem_addr <= mem_addr + 16'h0001;
					state_r  <= S_CNT;
				end
			end
			S_CNT: begin
				if (mem_req && mem_gnt) begin
					cnt_r    <= mem_rdata[`SPDC_CNT_HI:0];
					mem_req  <= 1'b1;
					mem_addr <= mem_addr + 16'h0001;
					state_r  <= S_ADR;
				end
			end
			S_ADR: begin
				if (mem_req && mem_gnt) begin
					adr_r         <= mem_rdata[`SPDC_ADR_HI:0];
					per_cmd_valid <= 1'b1;
					per_cmd       <= cmd_r;
					state_r       <= S_ISSUE;
				end
			end
			S_ISSUE: begin
				if (abort_pend_r) begin
					per_cmd_valid <= 1'b0;
					state_r       <= S_STAT;
				end else if (ack_sel) begin
					per_cmd_valid <= 1'b0;
					state_r       <= S_XFER;
				end
			end
			S_XFER: begin
				if (rx_take) begin
					issued_r <= issued_r + 16'h0001;
					if (~^{per_rx_data, per_rx_par})
						parerr_r <= 1'b1;
				end
				if (!dir_in && !mem_req && !abort_pend_r && issued_r < cnt_r &&
				    flevel < FDEPTH - 1) begin
					mem_req  <= 1'b1;
					mem_we   <= 1'b0;
					mem_addr <= adr_r + issued_r;
					issued_r <= issued_r + 16'h0001;
				end
				if (dir_in && fout_ready && fout_valid) begin
					mem_req   <= 1'b1;
					mem_we    <= 1'b1;
					mem_addr  <= adr_r + done_r;
					mem_wdata <= fout_data;
				end
				if (dir_in && mem_req && mem_gnt)
					done_r <= done_r + 16'h0001;
				// abort waits only for a request already on the channel
				if ((done_r == cnt_r) || (abort_pend_r && !mem_req)) begin
					fifo_flush_r <= 1'b1;
					per_tx_valid <= 1'b0;
					state_r      <= S_STAT;
				end
			end
			S_STAT: begin
				if (!mem_req) begin
					status_r <= 12'h000;
					status_r[`SPDC_ST_DONE]   <= ~abort_pend_r;
					status_r[`SPDC_ST_PARERR] <= parerr_r;
					status_r[`SPDC_ST_ABORT]  <= abort_pend_r;
					status_r[`SPDC_ST_INPUT]  <= dir_in;
					status_r[`SPDC_ST_CH_HI:`SPDC_ST_CH_LO] <= chsel_r;
					mem_req   <= 1'b1;
					mem_we    <= 1'b1;
					mem_addr  <= {11'h000, ptr_loc_r};
					mem_wdata <= {6'h00, chsel_r, dir_in, abort_pend_r, parerr_r,
						~abort_pend_r, ptr_word_r[`SPDC_PTR_Y_HI:`SPDC_PTR_Y_LO]};
					state_r   <= S_DONE;
				end
			end
			S_DONE: begin
				if (mem_req && mem_gnt) begin
					ptr_word_r <= {status_r, ptr_word_r[`SPDC_PTR_Y_HI:`SPDC_PTR_Y_LO]};
					mem_we     <= 1'b0;
					ready_irq  <= 1'b1;
					state_r    <= S_IDLE;
				end
			end
			default:
				state_r <= S_IDLE;
			endcase
		end
	end
endmodule // spdc_top

// File: tb/spdc_monitor.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
module spdc_monitor #(
	parameter NUM_CH = 4
) (
	// clock, reset and write handshakes
	input wire              aclk,
	input wire              aresetn,
	input wire              s_axi_wvalid,
	input wire              s_axi_wready,
	input wire              s_axi_bvalid,
	input wire              s_axi_bready,
	// shared memory channel
	input wire              mem_req,
	input wire              mem_we,
	input wire [15:0]       mem_addr,
	input wire              mem_gnt,
	input wire              ready_irq,
	// peripheral channels
	input wire [NUM_CH-1:0] per_sel,
	input wire              per_cmd_valid,
	input wire [11:0]       per_cmd,
	input wire [NUM_CH-1:0] per_cmd_ack,
	input wire              per_tx_valid,
	input wire [23:0]       per_tx_data,
	input wire              per_tx_par,
	input wire [NUM_CH-1:0] per_tx_ready,
	input wire [NUM_CH-1:0] per_rx_valid,
	input wire              per_rx_ready
);
	// one domain, so clock and reset are given once
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_sel; (per_cmd_valid || per_tx_valid) |-> $onehot(per_sel) && $onehot0(per_sel); endproperty
	a_sel: assert property (p_sel) else $error("channel select not one-hot while active");
	property p_mem_hold; mem_req && !mem_gnt |=> mem_req && $stable(mem_addr) && $stable(mem_we); endproperty
	a_mem_hold: assert property (p_mem_hold) else $error("memory request dropped before grant");
	property p_cmd_first; per_tx_valid |-> !per_cmd_valid; endproperty
	a_cmd_first: assert property (p_cmd_first) else $error("data sent while command pending");
	property p_cmd_stable; per_cmd_valid && !(|(per_cmd_ack & per_sel)) |=> !per_cmd_valid || $stable(per_cmd); endproperty
	a_cmd_stable: assert property (p_cmd_stable) else $error("command changed before ack");
	property p_tx_par; per_tx_valid |-> per_tx_par == ~^per_tx_data; endproperty
	a_tx_par: assert property (p_tx_par) else $error("sent parity not odd");
	property p_tx_hold; per_tx_valid && !(|(per_tx_ready & per_sel)) |=> per_tx_valid && $stable(per_tx_data); endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("send word changed before taken");
	property p_rx_gap; per_rx_ready && |(per_rx_valid & per_sel) |=> !per_rx_ready; endproperty
	a_rx_gap: assert property (p_rx_gap) else $error("receive ready did not drop after take");
	property p_irq_cause;
		ready_irq |-> $past(mem_req && mem_gnt && mem_we) || $past(s_axi_wvalid && s_axi_wready)
			|| $past(s_axi_wvalid && s_axi_wready, 2) || $past(s_axi_wvalid && s_axi_wready, 3);
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("ready interrupt without cause");
	property p_irq_pulse; ready_irq |=> !ready_irq; endproperty
	a_irq_pulse: assert property (p_irq_pulse) else $error("ready interrupt longer than a cycle");
	property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
	a_bhold: assert property (p_bhold) else $error("write response withdrawn");
endmodule // spdc_monitor

bind spdc_top spdc_monitor #(.NUM_CH(NUM_CH)) u_mon (.aclk(aclk), .aresetn(aresetn), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .mem_req(mem_req),
	.mem_we(mem_we), .mem_addr(mem_addr), .mem_gnt(mem_gnt), .ready_irq(ready_irq), .per_sel(per_sel),
	.per_cmd_valid(per_cmd_valid), .per_cmd(per_cmd), .per_cmd_ack(per_cmd_ack), .per_tx_valid(per_tx_valid),
	.per_tx_data(per_tx_data), .per_tx_par(per_tx_par), .per_tx_ready(per_tx_ready),
	.per_rx_valid(per_rx_valid), .per_rx_ready(per_rx_ready));

// File: tb/spdc_sub.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
module spdc_sub #(
	parameter NUM_CH = 4
) (
	// clock, reset and scenario knobs
	input  wire               aclk,
	input  wire               aresetn,
	input  wire               slow,
	input  wire               hold_ack,
	input  wire               bad_first,
	input  wire [15:0]        rx_len,
	// channel lines
	input  wire [NUM_CH-1:0]  per_sel,
	input  wire               per_cmd_valid,
	input  wire [11:0]        per_cmd,
	output logic [NUM_CH-1:0] per_cmd_ack,
	input  wire               per_tx_valid,
	input  wire [23:0]        per_tx_data,
	input  wire               per_tx_par,
	output logic [NUM_CH-1:0] per_tx_ready,
	output logic [NUM_CH-1:0] per_rx_valid,
	output logic [23:0]       per_rx_data,
	output logic              per_rx_par,
	input  wire               per_rx_ready
);
	logic [11:0]       cmd_seen;
	logic [NUM_CH-1:0] sel_seen;
	logic [23:0]       tx_q [0:63];
	int                tx_n, par_bad, rx_i, rx_left, cyc;

	// selected subsystem; slow ready opens one cycle in eight so words back up in the buffer
	always @(posedge aclk) begin
		if (!aresetn) begin
			per_cmd_ack <= '0;
			per_tx_ready <= '0;
			per_rx_valid <= '0;
			per_rx_data <= 24'h000000;
			per_rx_par <= 1'b0;
			{rx_left, tx_n, par_bad, cyc} <= '0;
		end else begin
			cyc <= cyc + 1;
			per_cmd_ack <= (per_cmd_valid && !hold_ack && per_cmd_ack == '0) ? per_sel : '0;
			if (per_cmd_valid && |(per_cmd_ack & per_sel)) begin
				cmd_seen <= per_cmd;
				sel_seen <= per_sel;
				rx_i <= 0;
				rx_left <= per_cmd[5] ? int'(rx_len) : 0;
			end
			per_tx_ready <= (!slow || cyc % 8 == 0) ? per_sel : '0;
			if (per_tx_valid && |(per_tx_ready & per_sel)) begin
				tx_q[tx_n] <= per_tx_data;
				tx_n <= tx_n + 1;
				if (per_tx_par !== ~^per_tx_data) par_bad <= par_bad + 1;
			end
			// released lines flip so a stale word cannot pass for a fresh one
			if (|(per_rx_valid & per_sel) && per_rx_ready) begin
				per_rx_valid <= '0;
				per_rx_data <= ~per_rx_data;
				per_rx_par <= ~per_rx_par;
				rx_left <= rx_left - 1;
				rx_i <= rx_i + 1;
			end else if (per_rx_valid == '0 && rx_left > 0) begin
				per_rx_valid <= per_sel;
				per_rx_data <= 24'h5A0000 + rx_i[23:0];
				per_rx_par <= ~^(24'h5A0000 + rx_i[23:0]) ^ (bad_first && rx_i == 0);
			end
		end
	end
endmodule // spdc_sub

// File: tb/testbench.sv
`timescale 1ns/100ps
`include "spdc_map.vh"
////////////////////////////////////////////////////////////////////////////////
module testbench;
	logic        aclk = 1'b0, aresetn = 1'b0, mem_gnt = 1'b0, mtog = 1'b0;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic [23:0] mem_rdata = 24'h0;
	logic        slow = 0, hold_ack = 0, bad_first = 0;
	logic [15:0] rx_len = 16'h0;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, mem_req, mem_we;
	wire [1:0]   s_axi_bresp, s_axi_rresp;
	wire [31:0]  s_axi_rdata;
	wire [15:0]  mem_addr;
	wire [23:0]  mem_wdata, per_tx_data, per_rx_data;
	wire         ready_irq, per_load, per_cmd_valid, per_tx_valid, per_tx_par, per_rx_par, per_rx_ready;
	wire [3:0]   per_sel, per_cmd_ack, per_tx_ready, per_rx_valid;
	wire [11:0]  per_cmd;
	logic [23:0] mem [0:511];
	int          error_cnt = 0, samples_checked = 0, irq_cnt = 0, load_cnt = 0;

	always #5 aclk = ~aclk;

	spdc_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mem_req, .mem_we, .mem_addr,
		.mem_wdata, .mem_gnt, .mem_rdata, .ready_irq, .per_sel, .per_load, .per_cmd_valid, .per_cmd, .per_cmd_ack,
		.per_tx_valid, .per_tx_data, .per_tx_par, .per_tx_ready, .per_rx_valid, .per_rx_data, .per_rx_par,
		.per_rx_ready);
	spdc_sub u_sub (.aclk, .aresetn, .slow, .hold_ack, .bad_first, .rx_len, .per_sel, .per_cmd_valid, .per_cmd,
		.per_cmd_ack, .per_tx_valid, .per_tx_data, .per_tx_par, .per_tx_ready, .per_rx_valid, .per_rx_data,
		.per_rx_par, .per_rx_ready);

	// shared channel: grants every other chance, so requests must wait
	always @(posedge aclk) begin
		mtog <= ~mtog;
		mem_gnt <= mem_req && !mem_gnt && mtog;
		mem_rdata <= (mem_req && !mem_gnt) ? mem[mem_addr[8:0]] : ~mem_rdata;
		if (mem_req && mem_gnt && mem_we) mem[mem_addr[8:0]] <= mem_wdata;
		if (ready_irq) irq_cnt <= irq_cnt + 1;
		if (per_load) load_cnt <= load_cnt + 1;
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task test_done;
		$display("errors %0d checks %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		@(posedge aclk);
		{s_axi_awaddr, s_axi_wdata} <= {a, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		for (n = 0; n < 60; n++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'b0;
		chk({29'h0, s_axi_bvalid, s_axi_bresp}, {29'h0, 1'b1, er});
	endtask

	task rdc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'b11;
		for (n = 0; n < 60; n++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, ed);
		chk({29'h0, s_axi_rvalid, s_axi_rresp}, {29'h0, 1'b1, er});
	endtask

	// loads the three control words, starts, optionally aborts, waits for the interrupt
	task start(input logic [4:0] loc, input logic [1:0] ch, input logic [11:0] y, input logic [23:0] c0, c1, c2,
		input logic abort_instr);
		int k, n0;
		{mem[y], mem[y + 1], mem[y + 2]} = {c0, c1, c2};
		wr(`SPDC_OFS_PTR_LOC, {27'h0, loc}, `SPDC_RESP_OKAY);
		wr(`SPDC_OFS_CHSEL, {30'h0, ch}, `SPDC_RESP_OKAY);
		n0 = irq_cnt;
		wr(`SPDC_OFS_PTR_WORD, {20'h0, y}, `SPDC_RESP_OKAY);
		if (abort_instr) wr(`SPDC_OFS_CTRL, 32'h1, `SPDC_RESP_OKAY);
		for (k = 0; k < 3000 && irq_cnt == n0; k++) @(posedge aclk);
		repeat (3) @(posedge aclk);
		chk(irq_cnt - n0, 1);
	endtask

	task t_regs;
		rdc(`SPDC_OFS_PTR_LOC, 32'h19, `SPDC_RESP_OKAY);
		wr(`SPDC_OFS_PTR_LOC, 32'h10, `SPDC_RESP_OKAY);
		rdc(`SPDC_OFS_PTR_LOC, 32'h19, `SPDC_RESP_OKAY);
		wr(`SPDC_OFS_CHSEL, 32'h3, `SPDC_RESP_OKAY);
		wr(`SPDC_OFS_CHSEL, 32'h4, `SPDC_RESP_OKAY);
		rdc(`SPDC_OFS_CHSEL, 32'h3, `SPDC_RESP_OKAY);
		rdc(8'h40, 32'h0, `SPDC_RESP_SLVERR);
		wr(8'h40, 32'h0, `SPDC_RESP_SLVERR);
	endtask

	// forty words against a stalling far side back up in the 32-word buffer, but it never reaches the 31 words at which fetches stop
	task t_out;
		int i;
		for (i = 0; i < 40; i++) mem[9'h100 + i] = 24'hA50000 ^ (i * 24'h010203);
		slow = 1'b1;
		start(5'h1B, 2'd2, 12'h040, 24'h0000C1, 24'h000028, 24'h000100, 1'b0);
		slow = 1'b0;
		chk(u_sub.cmd_seen, 12'h0C1);
		chk(u_sub.sel_seen, 4'b0100);
		chk(u_sub.tx_n, 40);
		for (i = 0; i < 40; i++) chk(u_sub.tx_q[i], mem[9'h100 + i]);
		chk(u_sub.par_bad, 0);
		chk(mem[9'h01B], {12'h021, 12'h040});
		rdc(`SPDC_OFS_PTR_WORD, {8'h00, 12'h021, 12'h040}, `SPDC_RESP_OKAY);
		rdc(`SPDC_OFS_STATUS, 32'h00002810, `SPDC_RESP_OKAY);
	endtask

	// unused high bits set, bad parity on the first character, top pointer location
	task t_in;
		{rx_len, bad_first} = {16'd2, 1'b1};
		start(5'h1F, 2'd1, 12'h050, 24'hFFF161, 24'hFF0002, 24'hFF01C0, 1'b0);
		bad_first = 1'b0;
		chk(u_sub.cmd_seen, 12'h161);
		chk(mem[9'h1C0], 24'h5A0000);
		chk(mem[9'h1C1], 24'h5A0001);
		chk(mem[9'h01F], {12'h01B, 12'h050});
	endtask

	task t_zero_abort;
		start(5'h19, 2'd0, 12'h060, 24'h000041, 24'h000000, 24'h000100, 1'b0);
		chk(mem[9'h019], {12'h001, 12'h060});
		hold_ack = 1'b1;
		start(5'h1A, 2'd3, 12'h070, 24'h000081, 24'h000004, 24'h000100, 1'b1);
		hold_ack = 1'b0;
		chk(mem[9'h01A], {12'h034, 12'h070});
		chk(u_sub.tx_n, 40);
	endtask

	task t_act;
		int n0, l0;
		{n0, l0} = {irq_cnt, load_cnt};
		wr(`SPDC_OFS_CTRL, 32'h6, `SPDC_RESP_OKAY);
		repeat (3) @(posedge aclk);
		chk(irq_cnt - n0, 1);
		chk(load_cnt - l0, 1);
	endtask

	// watchdog, well past the few hundred cycles the tests need
	initial begin
		#500000;
		error_cnt++;
		test_done;
	end

	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs;
		t_out;
		t_in;
		t_zero_abort;
		t_act;
		test_done;
	end
endmodule // testbench
